// ===== hw/fhdvt_params.svh
// Purpose: constants of the panel video host: timing counts, delays, sizes
// Assumes: core clock of 250 MHz, panel pixel clock made by an integer divider
// Notes:   figures live here once, save the host's fixed divide by four and the checker's counts; the package holds only types
// How it works
// (R1) pixel clock between 60 and 80 MHz
// (R2) spread spectrum within two percent of nominal
// (R3) spread modulation rate at most 200 kHz
// (R4) fifty hertz case stays 47 to 53 fps
// (R5) sixty hertz case stays 57 to 63 fps
// (R6) frame total 1125 lines, never above 1480
// (R7) exactly 1080 active lines in full mode
// (R8) vertical blanking 45 lines, at most 400; half mode blanks 585 lines
// (R9) line total 1030 to 1325 clocks, nominal 1100
// (R10) exactly 960 active clocks per line
// (R11) horizontal blanking 70 to 365, nominal 140
// (R12) totals fit both clock limits at frame rates
// (R13) panel times everything from qualifier alone
// (R14) half mode sends 540 active lines
// (R15) supply off means inputs low, never high
// (R16) signals start only after supply is up
// (R17) every signal actively driven while powered
// (R18) backlight on after video, off before it
// (R19) eight bit codes, larger means brighter
// (R20) qualifier high only on active pixel clocks
`ifndef FHDVT_PARAMS_SVH
`define FHDVT_PARAMS_SVH

// ****************************************************************
// clocking
// ****************************************************************
`define FHDVT_CORE_MHZ        250
`define FHDVT_PCLK_DIV        4
`define FHDVT_PCLK_MIN_KHZ    60000
`define FHDVT_PCLK_MAX_KHZ    80000
`define FHDVT_PCLK_KHZ        ((`FHDVT_CORE_MHZ * 1000) / `FHDVT_PCLK_DIV)

// ****************************************************************
// raster, in pixel clocks and line periods
// ****************************************************************
`define FHDVT_H_ACTIVE        11'd960
`define FHDVT_H_TOTAL         11'd1100
`define FHDVT_V_ACTIVE        11'd1080
`define FHDVT_V_HALF          11'd540
`define FHDVT_V_TOTAL         11'd1125
`define FHDVT_V_TOTAL_MAX     1480

// ****************************************************************
// power sequencing
// ****************************************************************
`define FHDVT_SUP2SIG_US      1000
`define FHDVT_SUP2SIG_CYC     (`FHDVT_SUP2SIG_US * `FHDVT_CORE_MHZ)
`define FHDVT_BL_ON_FRAMES    2'd2
`define FHDVT_BL_OFF_FRAMES   2'd1

// ****************************************************************
// buffering
// ****************************************************************
`define FHDVT_FIFO_DEPTH      8
`define FHDVT_BLACK           8'h00

`endif

// ===== hw/fhdvt_pkg.sv
// Purpose: types shared by the panel video host files
// Assumes: nothing beyond plain SystemVerilog
// Notes:   constants live in fhdvt_params.svh
package fhdvt_pkg;

  // one pixel, eight bit code per primary
  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } fhdvt_rgb_s;

  // two pixels carried per pixel clock on the dual link
  typedef struct packed {
    fhdvt_rgb_s odd;
    fhdvt_rgb_s even;
  } fhdvt_pair_s;

  // power sequence states
  typedef enum logic [2:0] {
    PWR_OFF,
    PWR_SUPPLY,
    PWR_VIDEO,
    PWR_LIGHT,
    PWR_DIM,
    PWR_DRAIN
  } fhdvt_pwr_e;

endpackage

// ===== hw/fhdvt_fifo.sv
// Purpose: small synchronous FIFO between the pixel source and the raster
// Assumes: one clock, synchronous active low reset
// Notes:   read data come out of a register loaded on every pop or refill
`timescale 1ns/1ps
`default_nettype none

module fhdvt_fifo #(
  parameter int unsigned WIDTH = 48,
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input  wire logic             i_core_clk,
  input  wire logic             i_nrst,
  // filling side
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  // draining side
  output logic                  o_out_valid,
  output logic      [WIDTH-1:0] o_out_data,
  input  wire logic             i_out_ready
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q, wr_d, rd_q, rd_d, cnt;
  logic [WIDTH-1:0] out_q, out_d;
  logic             push, pop;

  // honest full and empty from the pointer difference
  assign cnt         = wr_q - rd_q;
  assign o_in_ready  = (cnt != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt != '0);
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;
  assign o_out_data  = out_q;

  // next pointers and the registered head word
  always_comb begin
    wr_d  = push ? wr_q + 1'b1 : wr_q;
    rd_d  = pop ? rd_q + 1'b1 : rd_q;
    // head register always shows the entry at the next read pointer
    out_d = (push && (wr_q == rd_d)) ? i_in_data : mem_q[rd_d[AW-1:0]];
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      out_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      out_q <= out_d;
    end
  end

  // storage has no reset; valid bits come from the pointers
  always_ff @(posedge i_core_clk) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= i_in_data;
    end
  end

endmodule

`default_nettype wire

// ===== hw/fhdvt_host.sv
// Purpose: host video source driving a 1920x1080 panel in qualifier-only mode
// Assumes: pixel stream and control come from logic on i_core_clk
// Notes:   pixel clock is core clock divided by four, no spread spectrum
//          half mode is picked up only while stopped or at a frame end
//          the buffer keeps its words across a power cycle
`timescale 1ns/1ps
`default_nettype none
`include "fhdvt_params.svh"

module fhdvt_host #(
  parameter int unsigned P_SUP2SIG_CYC = `FHDVT_SUP2SIG_CYC
) (
  // clock and reset
  input  wire logic                 i_core_clk,
  input  wire logic                 i_nrst,
  // control
  input  wire logic                 i_power_req,
  input  wire logic                 i_half_mode,
  // pixel stream in, two pixels per word
  input  wire logic                 i_pix_valid,
  input  wire fhdvt_pkg::fhdvt_pair_s i_pix,
  output logic                      o_pix_ready,
  // panel pins
  output logic                      o_panel_supply_en,
  output logic                      o_link_clk,
  output logic                      o_active_video_qualifier,
  output fhdvt_pkg::fhdvt_pair_s    o_pix,
  output logic                      o_backlight_en,
  // status
  output logic                      o_video_on,
  output logic                      o_frame_start,
  output logic                      o_underrun
);

  // ****************************************************************
  // buffering between the source and the raster
  // ****************************************************************

  // head of the buffer and the raster's take strobe
  logic                   fifo_valid;
  logic                   fifo_pop;
  fhdvt_pkg::fhdvt_pair_s fifo_data;

  // the raster drains only on active clocks, so the source stalls in blanking
  // width follows the pair struct so the two cannot drift apart
  fhdvt_fifo #(
    .WIDTH ($bits(fhdvt_pkg::fhdvt_pair_s)),
    .DEPTH (`FHDVT_FIFO_DEPTH)
  ) u_fifo (
    .i_core_clk  (i_core_clk),
    .i_nrst      (i_nrst),
    .i_in_valid  (i_pix_valid),
    .i_in_data   (i_pix),
    .o_in_ready  (o_pix_ready),
    .o_out_valid (fifo_valid),
    .o_out_data  (fifo_data),
    .i_out_ready (fifo_pop)
  );

  // ****************************************************************
  // power sequence
  // ****************************************************************

  // the timer stops one short because the state change costs an edge
  localparam logic [17:0] SUP2SIG_LAST = 18'(P_SUP2SIG_CYC - 1);

  // sequence state, delay timer, frame count and registered pins
  fhdvt_pkg::fhdvt_pwr_e pwr_q, pwr_d;
  logic [17:0]           tmr_q, tmr_d;
  logic [1:0]            frm_q, frm_d;
  logic                  sup_q, sup_d;
  logic                  bl_q, bl_d;
  logic                  run_q, run_d;
  logic                  frame_done;

  // supply first, then signals, then light; reverse on the way down
  always_comb begin
    pwr_d = pwr_q;
    tmr_d = tmr_q;
    frm_d = frm_q;
    case (pwr_q)
      fhdvt_pkg::PWR_OFF: begin
        // timer parked at zero so each delay starts clean
        tmr_d = '0;
        if (i_power_req) begin
          pwr_d = fhdvt_pkg::PWR_SUPPLY;
        end
      end
      fhdvt_pkg::PWR_SUPPLY: begin
        // signals wait out the full delay after supply comes up, see (R16)
        tmr_d = tmr_q + 18'h00001;
        // a request dropped here aborts before any signal was driven
        if (!i_power_req) begin
          pwr_d = fhdvt_pkg::PWR_OFF;
        end else if (tmr_q == SUP2SIG_LAST) begin
          pwr_d = fhdvt_pkg::PWR_VIDEO;
          frm_d = '0;
        end
      end
      fhdvt_pkg::PWR_VIDEO: begin
        // light only after whole valid frames have gone out, see (R18)
        if (frame_done) begin
          frm_d = frm_q + 2'h1;
        end
        // backlight still dark, so video may stop at once without a dim frame
        if (!i_power_req) begin
          pwr_d = fhdvt_pkg::PWR_DRAIN;
          tmr_d = '0;
        end else if (frm_q == `FHDVT_BL_ON_FRAMES) begin
          pwr_d = fhdvt_pkg::PWR_LIGHT;
        end
      end
      fhdvt_pkg::PWR_LIGHT: begin
        // backlight drops on the next edge while video keeps running, see (R18)
        if (!i_power_req) begin
          pwr_d = fhdvt_pkg::PWR_DIM;
          frm_d = '0;
        end
      end
      fhdvt_pkg::PWR_DIM: begin
        // video keeps running until the frame in progress ends with the light dark, see (R18)
        // requests are ignored until the sequence reaches off
        if (frame_done) begin
          frm_d = frm_q + 2'h1;
        end
        if (frm_q == `FHDVT_BL_OFF_FRAMES) begin
          pwr_d = fhdvt_pkg::PWR_DRAIN;
          tmr_d = '0;
        end
      end
      fhdvt_pkg::PWR_DRAIN: begin
        // signals are already low; hold supply a while before dropping it
        tmr_d = tmr_q + 18'h00001;
        if (tmr_q == SUP2SIG_LAST) begin
          pwr_d = fhdvt_pkg::PWR_OFF;
        end
      end
      default: begin
        // an unused code falls back to the safe state
        pwr_d = fhdvt_pkg::PWR_OFF;
      end
    endcase
    // pins follow the next state so they move on the same edge as it
    sup_d = (pwr_d != fhdvt_pkg::PWR_OFF);
    bl_d  = (pwr_d == fhdvt_pkg::PWR_LIGHT);
    run_d = (pwr_d == fhdvt_pkg::PWR_VIDEO) ||
            (pwr_d == fhdvt_pkg::PWR_LIGHT) ||
            (pwr_d == fhdvt_pkg::PWR_DIM);
  end

  // registers only; reset parks the sequence with every pin off
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      pwr_q <= fhdvt_pkg::PWR_OFF;
      tmr_q <= '0;
      frm_q <= '0;
      sup_q <= 1'b0;
      bl_q  <= 1'b0;
      run_q <= 1'b0;
    end else begin
      pwr_q <= pwr_d;
      tmr_q <= tmr_d;
      frm_q <= frm_d;
      sup_q <= sup_d;
      bl_q  <= bl_d;
      run_q <= run_d;
    end
  end

  // ****************************************************************
  // pixel clock divider and raster counters
  // ****************************************************************

  // divider, raster position and the registered panel pins
  logic [1:0]             div_q, div_d;
  logic                   clk_q, clk_d;
  logic [10:0]            hcnt_q, hcnt_d;
  logic [10:0]            vcnt_q, vcnt_d;
  logic                   half_q, half_d;
  logic                   de_q, de_d;
  fhdvt_pkg::fhdvt_pair_s pix_q, pix_d;
  logic                   fst_q, fst_d;
  logic                   und_q, und_d;
  logic                   pclk_en;
  logic                   active;
  logic                   h_last;
  logic                   v_last;
  logic [10:0]            v_active;
  fhdvt_pkg::fhdvt_pair_s black;

  // fixed divide by four gives 62.5 MHz with no spread, see (R1) (R2) (R3)
  assign pclk_en  = run_q && (div_q == 2'h3);
  // half mode shortens the active field only, see (R14)
  assign v_active = half_q ? `FHDVT_V_HALF : `FHDVT_V_ACTIVE;
  // 960 active clocks of 1100 and 1080 active lines of 1125, see (R7) (R10)
  assign active   = (hcnt_q < `FHDVT_H_ACTIVE) && (vcnt_q < v_active);
  // 140 clocks and 45 lines of blanking in full mode, see (R6) (R8) (R9) (R11)
  assign h_last   = (hcnt_q == `FHDVT_H_TOTAL - 11'd1);
  assign v_last   = (vcnt_q == `FHDVT_V_TOTAL - 11'd1);
  // 62.5 MHz over 1100 by 1125 is about 50.5 frames/s, see (R4) (R12)
  // only the fifty hertz case is produced, so the sixty hertz window
  // is never entered at this one fixed rate, see (R5)
  assign frame_done = pclk_en && h_last && v_last;
  // take a word only on an active clock that has one waiting,
  // and never on the edge that stops video, where it would be lost
  assign fifo_pop = pclk_en && run_d && active && fifo_valid;
  // constant black pair for blanking, stop and underrun
  assign black    = '{odd: '{red: `FHDVT_BLACK, green: `FHDVT_BLACK, blue: `FHDVT_BLACK},
                      even: '{red: `FHDVT_BLACK, green: `FHDVT_BLACK, blue: `FHDVT_BLACK}};

  // outputs change on the same core edge as the falling link clock edge
  always_comb begin
    div_d  = div_q;
    clk_d  = clk_q;
    hcnt_d = hcnt_q;
    vcnt_d = vcnt_q;
    half_d = half_q;
    de_d   = de_q;
    pix_d  = pix_q;
    fst_d  = 1'b0;
    und_d  = 1'b0;
    if (!run_d) begin
      // link pins low while video is stopped or supply is off, see (R15)
      div_d  = '0;
      clk_d  = 1'b0;
      hcnt_d = '0;
      vcnt_d = '0;
      half_d = i_half_mode;
      de_d   = 1'b0;
      pix_d  = black;
    end else begin
      // count of core cycles within one pixel clock
      div_d = div_q + 2'h1;
      // clock high on counts 2 and 3, so data change as it falls
      clk_d = div_d[1];
      if (pclk_en) begin
        // qualifier is the only timing the panel gets, see (R13) (R20)
        de_d  = active;
        // codes pass untouched, zero is darkest, see (R19)
        pix_d = fifo_pop ? fifo_data : black;
        // starvation only flags; the raster never waits for the source
        und_d = active && !fifo_valid;
        fst_d = (hcnt_q == '0) && (vcnt_q == '0);
        // line and frame wrap; the panel fixes only the active window
        if (h_last) begin
          hcnt_d = '0;
          if (v_last) begin
            vcnt_d = '0;
            // mode changes only between frames to keep the panel's field intact
            half_d = i_half_mode;
          end else begin
            vcnt_d = vcnt_q + 11'd1;
          end
        end else begin
          hcnt_d = hcnt_q + 11'd1;
        end
      end
    end
  end

  // registers only; reset leaves the link idle and black
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      div_q  <= '0;
      clk_q  <= 1'b0;
      hcnt_q <= '0;
      vcnt_q <= '0;
      half_q <= 1'b0;
      de_q   <= 1'b0;
      pix_q  <= '0;
      fst_q  <= 1'b0;
      und_q  <= 1'b0;
    end else begin
      div_q  <= div_d;
      clk_q  <= clk_d;
      hcnt_q <= hcnt_d;
      vcnt_q <= vcnt_d;
      half_q <= half_d;
      de_q   <= de_d;
      pix_q  <= pix_d;
      fst_q  <= fst_d;
      und_q  <= und_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************

  // every pin is driven from a flop at all times, never floated, see (R17)
  assign o_panel_supply_en        = sup_q;
  assign o_link_clk               = clk_q;
  assign o_active_video_qualifier = de_q;
  assign o_pix                    = pix_q;
  assign o_backlight_en           = bl_q;
  // status lets the source pace itself and watch for starvation
  assign o_video_on               = run_q;
  assign o_frame_start            = fst_q;
  // an underrun shows black rather than stalling the raster
  assign o_underrun               = und_q;

endmodule

`default_nettype wire

// ===== dv/fhdvt_panel_model.sv
// Purpose: behavioural panel on the far side of the host's link
// Assumes: link clock far slower than the core clock that samples it
// Notes:   line timing is recovered from the qualifier alone
`timescale 1ns/1ps
`default_nettype none
module fhdvt_panel_model (
  // clock
  input  wire logic                   i_core_clk,
  // panel pins
  input  wire logic                   i_supply_en,
  input  wire logic                   i_link_clk,
  input  wire logic                   i_qual,
  input  wire fhdvt_pkg::fhdvt_pair_s i_pix,
  // figures seen
  output logic [11:0]                 o_act_len,
  output logic [11:0]                 o_blank_len,
  output logic [11:0]                 o_lines,
  output logic [7:0]                  o_errs
);
  logic                   lc_q;
  logic                   qv_q;
  logic [11:0]            run_q;
  fhdvt_pkg::fhdvt_pair_s pix_log [8];
  int                     pix_n;
  initial begin
    {lc_q, qv_q, run_q, o_act_len, o_blank_len, o_lines, o_errs} = '0;
    pix_n = 0;
  end
  // ****************************************************************
  // receiver
  // ****************************************************************
  // an input driven high without supply would stress the unpowered panel
  always @(posedge i_core_clk) begin
    lc_q <= i_link_clk;
    if (!i_supply_en && (i_link_clk || i_qual || i_pix != '0))
      o_errs <= o_errs + 8'h01;
    if (i_supply_en && $isunknown({i_link_clk, i_qual}))
      o_errs <= o_errs + 8'h01;
    // no sync pins: qualifier edges alone give lines
    if (i_link_clk && !lc_q) begin
      qv_q <= i_qual;
      run_q <= (i_qual == qv_q) ? run_q + 12'h001 : 12'h001;
      if (i_qual && !qv_q)
        o_blank_len <= run_q;
      // in half mode only the first 540 lines would carry picture
      if (!i_qual && qv_q) begin
        o_act_len <= run_q;
        o_lines <= o_lines + 12'h001;
      end
      // codes kept as sent, larger is brighter
      if (i_qual && pix_n < 8) begin
        pix_log[pix_n] <= i_pix;
        pix_n <= pix_n + 1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== dv/fhdvt_host_asserts.sv
// Purpose: timing checks on the ports of the panel video host
// Assumes: one core clock domain, pixel clock of four core cycles
// Notes:   run lengths are counted in core cycles by helper logic
`timescale 1ns/1ps
`default_nettype none
module fhdvt_host_asserts #(
  parameter int unsigned P_SUP2SIG_CYC = 16
) (
  // clock and reset
  input wire logic                   i_core_clk,
  input wire logic                   i_nrst,
  // panel pins and status
  input wire logic                   o_panel_supply_en,
  input wire logic                   o_link_clk,
  input wire logic                   o_active_video_qualifier,
  input wire fhdvt_pkg::fhdvt_pair_s o_pix,
  input wire logic                   o_backlight_en,
  input wire logic                   o_video_on,
  input wire logic                   o_frame_start,
  input wire logic                   o_underrun
);
  localparam int unsigned ACT_CYC = 3840;
  localparam int unsigned BLK_CYC = 560;
  logic [11:0] hi_q, hi_d, lo_q, lo_d;
  logic [31:0] sup_q, sup_d;
  // 12 bits wrap in vertical blanking; only line gaps are judged
  always_comb begin
    hi_d = o_active_video_qualifier ? hi_q + 12'h001 : 12'h000;
    lo_d = o_active_video_qualifier ? 12'h000 : lo_q + 12'h001;
    sup_d = o_panel_supply_en ? sup_q + 32'h1 : 32'h0;
  end
  always_ff @(posedge i_core_clk) begin
    hi_q <= i_nrst ? hi_d : 12'h000;
    lo_q <= i_nrst ? lo_d : 12'h000;
    sup_q <= i_nrst ? sup_d : 32'h0;
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  sequence s_link_half;
    $rose(o_link_clk) ##1 o_link_clk ##1 !o_link_clk ##1 !o_link_clk;
  endsequence
  property p_supply_first;
    (o_active_video_qualifier || o_link_clk || o_video_on) |-> o_panel_supply_en;
  endproperty
  property p_off_quiet;
    !o_panel_supply_en |-> !o_link_clk && !o_active_video_qualifier && o_pix == '0 && !o_backlight_en;
  endproperty
  property p_light_video;
    o_backlight_en |-> o_video_on;
  endproperty
  property p_sup_delay;
    $rose(o_video_on) |-> sup_q inside {[P_SUP2SIG_CYC - 1 : P_SUP2SIG_CYC + 1]};
  endproperty
  property p_link_rate;
    s_link_half |-> ##1 (o_link_clk || !o_video_on);
  endproperty
  property p_qual_edge;
    $changed(o_active_video_qualifier) && o_video_on |-> $fell(o_link_clk);
  endproperty
  property p_frame_start;
    o_frame_start |-> o_active_video_qualifier ##1 !o_frame_start;
  endproperty
  property p_underrun;
    o_underrun |-> o_active_video_qualifier && o_pix == '0;
  endproperty
  property p_blank_black;
    !o_active_video_qualifier |-> o_pix == '0;
  endproperty
  property p_active_len;
    $fell(o_active_video_qualifier) && o_video_on |-> hi_q == ACT_CYC;
  endproperty
  property p_blank_len;
    $rose(o_active_video_qualifier) && !o_frame_start |-> lo_q == BLK_CYC;
  endproperty
  a_supply_first: assert property (p_supply_first) else $error("link driven without supply");
  a_off_quiet: assert property (p_off_quiet) else $error("pin high while supply off");
  a_light_video: assert property (p_light_video) else $error("backlight on without video");
  a_sup_delay: assert property (p_sup_delay) else $error("video started early or late");
  a_link_rate: assert property (p_link_rate) else $error("pixel clock period wrong");
  a_qual_edge: assert property (p_qual_edge) else $error("qualifier off the launch edge");
  a_frame_start: assert property (p_frame_start) else $error("frame start pulse wrong");
  a_underrun: assert property (p_underrun) else $error("underrun not black");
  a_blank_black: assert property (p_blank_black) else $error("picture in blanking");
  a_active_len: assert property (p_active_len) else $error("active line length wrong");
  a_blank_len: assert property (p_blank_len) else $error("line blanking length wrong");
endmodule
bind fhdvt_host fhdvt_host_asserts #(.P_SUP2SIG_CYC(P_SUP2SIG_CYC)) u_chk (.i_core_clk, .i_nrst,
  .o_panel_supply_en, .o_link_clk, .o_active_video_qualifier, .o_pix, .o_backlight_en, .o_video_on,
  .o_frame_start, .o_underrun);
`default_nettype wire

// ===== dv/tb.sv
// Purpose: self-checking bench of the panel video host
// Assumes: supply delay shortened to 16 cycles
// Notes:   a frame is too long to run, so lines are judged, not frames
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int unsigned P = 16;
  logic                   clk = 1'b0, nrst = 1'b0, req = 1'b0, vld = 1'b0, unr_seen = 1'b0, half = 1'b0;
  fhdvt_pkg::fhdvt_pair_s pix = '0, opix;
  logic                   rdy, sup, lclk, qual, bl, von, fs, unr;
  logic [11:0]            act, blk, lines;
  logic [7:0]             errs;
  int                     fails = 0, checks = 0, fs_n = 0;
  always #2 clk = ~clk;
  always @(posedge clk) if (unr === 1'b1) unr_seen <= 1'b1;
  always @(posedge clk) if (fs === 1'b1) fs_n <= fs_n + 1;
  fhdvt_host #(.P_SUP2SIG_CYC(P)) u_dut (.i_core_clk(clk), .i_nrst(nrst), .i_power_req(req),
    .i_half_mode(half), .i_pix_valid(vld), .i_pix(pix), .o_pix_ready(rdy), .o_panel_supply_en(sup),
    .o_link_clk(lclk), .o_active_video_qualifier(qual), .o_pix(opix), .o_backlight_en(bl),
    .o_video_on(von), .o_frame_start(fs), .o_underrun(unr));
  fhdvt_panel_model u_panel (.i_core_clk(clk), .i_supply_en(sup), .i_link_clk(lclk), .i_qual(qual),
    .i_pix(opix), .o_act_len(act), .o_blank_len(blk), .o_lines(lines), .o_errs(errs));
  function automatic fhdvt_pkg::fhdvt_pair_s word(input int k);
    return {6{8'(8'h11 * (k + 1))}};
  endfunction
  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // 0 video on, 1 video off, 2 supply off, 3 two lines seen
  task automatic wait_on(input int s, input int lim);
    int n;
    n = 0;
    while (((s == 0) ? von : (s == 1) ? !von : (s == 2) ? !sup : lines >= 12'd2) !== 1'b1) begin
      @(posedge clk) #1;
      n++;
      if (n >= lim) begin
        fails++;
        $display("[ERR] wait %0d expected done seen timeout", s);
        end_sim();
      end
    end
  endtask
  task automatic t_reset();
    @(posedge clk) #1;
    chk("quiet pins", 0, {sup, lclk, qual, bl, von, fs, unr, opix});
    chk("ready", 1, rdy);
    $display("test reset done");
  endtask
  // fill until the buffer refuses; nothing drains while stopped
  task automatic t_fill();
    for (int k = 0; k < 8; k++) begin
      @(posedge clk) vld <= 1'b1;
      pix <= word(k);
      #1 chk("ready", 1, rdy);
    end
    @(posedge clk) vld <= 1'b0;
    #1 chk("ready full", 0, rdy);
    $display("test fill done");
  endtask
  task automatic t_abort();
    @(posedge clk) req <= 1'b1;
    repeat (3) @(posedge clk);
    req <= 1'b0;
    #1 chk("supply up", 1, sup);
    wait_on(2, 8);
    chk("no video", 0, {von, qual, lclk});
    $display("test abort done");
  endtask
  // half mode on: the first lines must match full mode, only the field shrinks
  task automatic t_lines();
    @(posedge clk) req <= 1'b1;
    half <= 1'b1;
    @(posedge clk) #1 chk("supply", 1, sup);
    chk("video early", 0, von);
    wait_on(0, P + 4);
    wait_on(3, 12000);
    chk("active len", 960, act);
    chk("blank len", 140, blk);
    chk("line total", 1100, act + blk);
    for (int k = 0; k < 8; k++) chk("pixel", word(k), u_panel.pix_log[k]);
    chk("underrun", 1, unr_seen);
    chk("frame starts", 1, fs_n);
    chk("backlight", 0, bl);
    $display("test lines done");
  endtask
  task automatic t_down();
    @(posedge clk) req <= 1'b0;
    half <= 1'b0;
    wait_on(1, 8);
    chk("signals off", 0, {qual, lclk, bl});
    chk("supply held", 1, sup);
    wait_on(2, P + 8);
    chk("panel errors", 0, errs);
    $display("test down done");
  endtask
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_fill();
    t_abort();
    t_lines();
    t_down();
    end_sim();
  end
endmodule
`default_nettype wire
